// File: pkg/dcsp_cfg.svh
/*
 Constants for the daisy chain serial peripheral: register offsets, reset values,
 field positions and frame codes. Assumes inclusion by bare name from design files.
*/
`ifndef DCSP_CFG_SVH
`define DCSP_CFG_SVH
// Register offsets.
`define DCSP_ADDR_IDENTITY   6'h00
`define DCSP_ADDR_DIGEST     6'h01
`define DCSP_ADDR_STAT1      6'h02
`define DCSP_ADDR_STAT2      6'h03
`define DCSP_ADDR_COMMAND    6'h08
`define DCSP_ADDR_OUTCTL     6'h09
`define DCSP_ADDR_CFG_FIRST  6'h0a
`define DCSP_ADDR_CFG_LAST   6'h0d
// Reset values.
`define DCSP_RST_DIGEST      8'h40
`define DCSP_RST_STAT1       8'h00
`define DCSP_RST_STAT2       8'h80
`define DCSP_RST_COMMAND     8'h09
`define DCSP_RST_OUTCTL      8'h0c
// Configuration bytes, the lowest address in bits 7:0.
`define DCSP_RST_CFG         32'h04400010
// Field positions.
`define DCSP_BIT_CHAIN       7
`define DCSP_BIT_READ        6
`define DCSP_BIT_PUMP_UV     5
`define DCSP_BIT_CLEAR_HDR   5
`define DCSP_BIT_FAULT_CLR   7
`define DCSP_LOCK_MSB        2
`define DCSP_LOCK_LSB        0
`define DCSP_LOCK_ON         3'h6
`define DCSP_OUTLOCK_MSB     3
`define DCSP_OUTLOCK_LSB     2
`define DCSP_OUTLOCK_ON      2'h2
// Byte prefixes of the chain protocol.
`define DCSP_HDR_PREFIX      2'h2
`define DCSP_PASS_PREFIX     2'h3
`define DCSP_STATUS_TOP      2'h3
`endif

// File: pkg/dcsp_pkg.sv
/*
 Types for the daisy chain serial peripheral. Assumes nothing beyond the language.
*/
package dcsp_pkg;
   // Frame phase as seen by this device.
   typedef enum logic [2:0] {DCSP_IDLE, DCSP_STATUS, DCSP_CHAIN_CLEAR_HEADER, DCSP_CMDS, DCSP_DATAS} dcsp_phase_e;
endpackage

// File: hdl/dcsp_sync.sv
/*
 Two flip-flop synchroniser for one pin level.
 Assumes the pin is asynchronous to clock_in.
*/
`timescale 1ns/100ps
module dcsp_sync
(
   // Clock and reset.
   input  wire logic clock_in,
   input  wire logic srst_in,
   // Pin and synchronised level.
   input  wire logic pin_in,
   input  wire logic reset_level_in,
   output logic      level_out
);
   // State: first and second stage.
   typedef struct packed {logic s1; logic s2;} dcsp_sync_s;
   dcsp_sync_s state;
   dcsp_sync_s next_state;

   // The first stage feeds only the second one.
   always_comb
   begin
      next_state.s1 = pin_in;
      next_state.s2 = state.s1;
   end

   // Register both stages.
   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         // Both stages start at the pin's idle level, so no false edge follows reset.
         state <= {reset_level_in, reset_level_in};
      end
      else
      begin
         state <= next_state;
      end
   end

   assign level_out = state.s2;
endmodule

// File: hdl/dcsp_peripheral.sv
/*
 Serial peripheral of a half-bridge driver with standard and daisy chain frames.
 Assumes the link pins are asynchronous and are oversampled by clock_in at 50 MHz.
*/
//******************************************************************************
// Summary of operation
//******************************************************************************
`timescale 1ns/100ps
`include "dcsp_cfg.svh"
module dcsp_peripheral
#(
   parameter logic [7:0] IDENTITY = 8'h5a   // Arbitrary identity value.
)
(
   // Clock and reset.
   input  wire logic       clock_in,
   input  wire logic       srst_in,
   // Serial link pins.
   input  wire logic       chip_select_n_in,
   input  wire logic       sclk_in,
   input  wire logic       sdi_in,
   output logic            sdo_out,
   output logic            sdo_oe_out,
   // Fault sources from the driver core.
   input  wire logic [1:0] open_load_active_in,
   input  wire logic [1:0] low_side_overcurrent_in,
   input  wire logic [1:0] high_side_overcurrent_in,
   input  wire logic       pump_undervoltage_in,
   input  wire logic [3:0] other_faults_in,
   // Control outputs.
   output logic [7:0]      out_control_out,
   output logic [31:0]     config_out,
   output logic            fault_clear_out,
   output logic            frame_error_out
);
   //***************************************************************************
   // Pin synchronisers
   //***************************************************************************
   logic cs_n;    // Synchronised chip select.
   logic sclk;    // Synchronised serial clock.
   logic sdi;     // Synchronised data in.
   dcsp_sync u_cs   (.clock_in(clock_in), .srst_in(srst_in), .pin_in(chip_select_n_in),
                     .reset_level_in(1'b1), .level_out(cs_n));
   dcsp_sync u_sclk (.clock_in(clock_in), .srst_in(srst_in), .pin_in(sclk_in),
                     .reset_level_in(1'b0), .level_out(sclk));
   dcsp_sync u_sdi  (.clock_in(clock_in), .srst_in(srst_in), .pin_in(sdi_in),
                     .reset_level_in(1'b0), .level_out(sdi));

   //***************************************************************************
   // State
   //***************************************************************************
   typedef struct packed
   {
      logic        cs_d;        // Previous chip select.
      logic        sclk_d;      // Previous serial clock.
      logic [2:0]  bitc;        // Bit within byte.
      logic [6:0]  bytec;       // Bytes in this frame.
      logic [7:0]  shin;        // Input shift register.
      logic [7:0]  shout;       // Output shift register.
      logic [7:0]  prev_byte;   // Last whole byte received.
      dcsp_pkg::dcsp_phase_e phase;
      logic        chain;       // Frame is a chain frame.
      logic [5:0]  pos;         // Status bytes before header.
      logic [5:0]  count;       // Chain device count.
      logic [5:0]  idx;         // Index inside command or data group.
      logic        clr_hdr;     // Global fault clear requested.
      logic        bad;         // Error found during frame.
      logic [7:0]  cmd;         // Own command byte.
      logic [7:0]  data;        // Own data byte.
      logic        sdo;         // Output bit.
      logic        oe;          // Output enable.
      logic        ferr;        // Frame error flag.
      logic        fclr;        // Fault clear pulse.
      logic [7:0]  command;     // Command register.
      logic [7:0]  outctl;      // Output control register.
      logic [31:0] cfg;         // Configuration registers.
      logic [3:0]  scratch;     // Spare scratch bits in status two.
   } dcsp_s;
   dcsp_s st;
   dcsp_s nx;

   // Summary bits and status registers.
   logic [7:0] digest;
   logic [7:0] stat1;
   logic [7:0] stat2;
   logic       open_load_active;
   logic       ocpl;
   logic       ocph;
   assign open_load_active  = |open_load_active_in;
   assign ocpl = |low_side_overcurrent_in;
   assign ocph = |high_side_overcurrent_in;
   // Digest: bit 6 reads one after reset as the ready indicator.
   assign digest = {1'b0, 1'b1, pump_undervoltage_in, open_load_active | ocpl | ocph, other_faults_in};
   assign stat1  = {2'h0, open_load_active, ocph, ocpl, 3'h0};
   assign stat2  = {1'b1, 3'h0, st.scratch};

   // Register read mux, value before any write.
   function automatic logic [7:0] rd(input logic [5:0] a, input dcsp_s s);
      logic [7:0] v;
      v = 8'h00;
      if (a == `DCSP_ADDR_IDENTITY) v = IDENTITY;
      else if (a == `DCSP_ADDR_DIGEST) v = digest;
      else if (a == `DCSP_ADDR_STAT1) v = stat1;
      else if (a == `DCSP_ADDR_STAT2) v = stat2;
      else if (a == `DCSP_ADDR_COMMAND) v = s.command;
      else if (a == `DCSP_ADDR_OUTCTL) v = s.outctl;
      else if (a >= `DCSP_ADDR_CFG_FIRST && a <= `DCSP_ADDR_CFG_LAST)
         v = s.cfg[8 * (a - `DCSP_ADDR_CFG_FIRST) +: 8];
      return v;
   endfunction

   // Whether the address is a mapped register.
   function automatic logic mapped(input logic [5:0] a);
      return (a <= `DCSP_ADDR_STAT2) || (a >= `DCSP_ADDR_COMMAND && a <= `DCSP_ADDR_CFG_LAST);
   endfunction

   //***************************************************************************
   // Next state
   //***************************************************************************
   logic       rise;
   logic       fall;
   logic [7:0] byte_in;
   logic [7:0] status;
   logic       own;
   logic [5:0] from_far;
   logic       newerr;      // An error is found at this frame end.
   always_comb
   begin
      nx = st;
      nx.cs_d = cs_n;
      nx.sclk_d = sclk;
      nx.fclr = 1'b0;
      rise = !cs_n && sclk && !st.sclk_d;
      fall = !cs_n && !sclk && st.sclk_d;
      byte_in = {st.shin[6:0], sdi};
      newerr = 1'b0;
      status = {`DCSP_STATUS_TOP, digest[5:0]};
      status[`DCSP_BIT_PUMP_UV] = st.ferr;
      own = 1'b0;
      from_far = st.count - st.pos - 6'h01;
      nx.oe = !cs_n;
      if (st.cs_d && !cs_n)
      begin
         // Frame opens: load status byte as the first output byte.
         nx.shout = status;
         nx.sdo = status[7];
      end
      // Launch on rising edge.
      // The first rise of a byte launches its top bit; on the first byte it repeats the preloaded bit.
      if (rise)
      begin
         nx.sdo = st.shout[7];
      end
      if (fall)
      begin
         nx.shin = byte_in;
         nx.shout = {st.shout[6:0], 1'b0};
         nx.bitc = st.bitc + 3'h1;
         if (st.bitc == 3'h7)
         begin
            nx.bytec = st.bytec + 7'h01;
            nx.prev_byte = byte_in;
            nx.shout = byte_in;
            case (st.phase)
               dcsp_pkg::DCSP_IDLE:
               begin
                  if (byte_in[`DCSP_BIT_CHAIN] == 1'b0)
                  begin
                     nx.cmd = byte_in;
                     nx.chain = 1'b0;
                     nx.phase = dcsp_pkg::DCSP_DATAS;
                     nx.shout = rd(byte_in[5:0], st);
                  end
                  else if (byte_in[7:6] == `DCSP_HDR_PREFIX)
                  begin
                     nx.chain = 1'b1;
                     nx.count = byte_in[5:0];
                     if (byte_in[5:0] == 6'h00) nx.bad = 1'b1;
                     nx.phase = dcsp_pkg::DCSP_CHAIN_CLEAR_HEADER;
                  end
                  else
                  begin
                     nx.pos = st.pos + 6'h01;
                  end
                  // Status and pass bytes are only counted, never processed.
               end
               dcsp_pkg::DCSP_CHAIN_CLEAR_HEADER:
               begin
                  nx.clr_hdr = byte_in[`DCSP_BIT_CLEAR_HDR];
                  if (byte_in[7:6] != `DCSP_HDR_PREFIX) nx.bad = 1'b1;
                  nx.idx = 6'h00;
                  nx.phase = dcsp_pkg::DCSP_CMDS;
               end
               dcsp_pkg::DCSP_CMDS:
               begin
                  if (st.idx == from_far)
                  begin
                     nx.cmd = byte_in;
                     own = 1'b1;
                  end
                  nx.idx = st.idx + 6'h01;
                  if (st.idx + 6'h01 == st.count)
                  begin
                     nx.idx = 6'h00;
                     nx.phase = dcsp_pkg::DCSP_DATAS;
                  end
               end
               dcsp_pkg::DCSP_DATAS:
               begin
                  if (!st.chain || st.idx == from_far) nx.data = byte_in;
                  nx.idx = st.idx + 6'h01;
                  if (!st.chain) nx.phase = dcsp_pkg::DCSP_STATUS;
               end
               default:
               begin
                  // Extra bytes past a standard frame only mark the frame as long.
                  nx.bad = 1'b1;
               end
            endcase
            if (own) nx.shout = rd(byte_in[5:0], st);
         end
      end
      // Frame closes.
      if (!st.cs_d && cs_n)
      begin
         // Check exact length.
         // Every device of a chain sees the same 16 plus 16 per device clocks.
         if (st.bitc != 3'h0 || st.bad || st.phase == dcsp_pkg::DCSP_IDLE ||
             st.phase == dcsp_pkg::DCSP_CHAIN_CLEAR_HEADER || st.phase == dcsp_pkg::DCSP_CMDS ||
             (!st.chain && st.bytec != 7'h02) ||
             (st.chain && st.bytec != {st.count, 1'b0} + 7'h02))
         begin
            nx.ferr = 1'b1;
            newerr = 1'b1;
         end
         else if (!mapped(st.cmd[5:0]))
         begin
            nx.ferr = 1'b1;
            newerr = 1'b1;
         end
         else if (!st.cmd[`DCSP_BIT_READ])
         begin
            if (st.cmd[5:0] == `DCSP_ADDR_COMMAND)
            begin
               nx.command = st.data;
               if (st.data[`DCSP_BIT_FAULT_CLR]) nx.fclr = 1'b1;
            end
            else if (st.cmd[5:0] == `DCSP_ADDR_OUTCTL)
            begin
               if (st.outctl[`DCSP_OUTLOCK_MSB:`DCSP_OUTLOCK_LSB] != `DCSP_OUTLOCK_ON ||
                   st.data[`DCSP_OUTLOCK_MSB:`DCSP_OUTLOCK_LSB] != `DCSP_OUTLOCK_ON)
                  nx.outctl = st.data;
            end
            else if (st.cmd[5:0] == `DCSP_ADDR_STAT2)
               nx.scratch = st.data[3:0];
            else if (st.cmd[5:0] >= `DCSP_ADDR_CFG_FIRST &&
                     st.command[`DCSP_LOCK_MSB:`DCSP_LOCK_LSB] != `DCSP_LOCK_ON)
               nx.cfg[8 * (st.cmd[5:0] - `DCSP_ADDR_CFG_FIRST) +: 8] = st.data;
         end
         if (st.chain && st.clr_hdr) nx.fclr = 1'b1;
         // A new error in the same frame wins over the clear.
         if (nx.fclr && !newerr) nx.ferr = 1'b0;
      end
      if (cs_n)
      begin
         nx.bitc = 3'h0;
         nx.bytec = 7'h00;
         nx.phase = dcsp_pkg::DCSP_IDLE;
         nx.pos = 6'h00;
         nx.idx = 6'h00;
         nx.bad = 1'b0;
         nx.chain = 1'b0;
         nx.clr_hdr = 1'b0;
      end
   end

   // Register the state.
   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         st <= '0;
         st.cs_d <= 1'b1;
         st.phase <= dcsp_pkg::DCSP_IDLE;
         st.command <= `DCSP_RST_COMMAND;
         st.outctl <= `DCSP_RST_OUTCTL;
         st.cfg <= `DCSP_RST_CFG;
      end
      else
      begin
         st <= nx;
      end
   end

   assign sdo_out = st.sdo;
   assign sdo_oe_out = st.oe;
   assign out_control_out = st.outctl;
   assign config_out = st.cfg;
   assign fault_clear_out = st.fclr;
   assign frame_error_out = st.ferr;

   //***************************************************************************
   // Assertions
   //***************************************************************************
   AST_RELEASED: assert property (@(posedge clock_in) disable iff (srst_in)
      cs_n |=> !sdo_oe_out) else $error("Output driven while deselected.");
   AST_BITS_CLEAR: assert property (@(posedge clock_in) disable iff (srst_in)
      cs_n |=> (st.bitc == 3'h0 && st.bytec == 7'h00)) else $error("Counters not reset.");
   AST_STATUS_TOP: assert property (@(posedge clock_in) disable iff (srst_in)
      (st.cs_d && !cs_n) |=> st.shout[7:6] == 2'h3) else $error("Status top bits not ones.");
   AST_ERR_BIT: assert property (@(posedge clock_in) disable iff (srst_in)
      (st.cs_d && !cs_n) |=> st.shout[5] == $past(st.ferr)) else $error("Status lacks error flag.");
   AST_SUMMARY: assert property (@(posedge clock_in) disable iff (srst_in)
      stat1[5] == (open_load_active_in[0] | open_load_active_in[1])) else $error("Open load summary wrong.");
   AST_NA_ZERO: assert property (@(posedge clock_in) disable iff (srst_in)
      stat1[7:6] == 2'h0 && stat1[2:0] == 3'h0) else $error("Unavailable bits not zero.");
   AST_LOCK: assert property (@(posedge clock_in) disable iff (srst_in)
      (st.command[2:0] == `DCSP_LOCK_ON) |=> $stable(st.cfg)) else $error("Locked config changed.");
   AST_SHORT: assert property (@(posedge clock_in) disable iff (srst_in)
      (!st.cs_d && cs_n && st.bitc != 3'h0) |=> (st.ferr && $stable(st.cfg) && $stable(st.outctl)))
      else $error("Short frame accepted.");
   AST_FCLR: assert property (@(posedge clock_in) disable iff (srst_in)
      st.fclr |-> st.cs_d && !$past(st.cs_d) && $past(cs_n)) else $error("Clear outside frame end.");
endmodule

// File: verification/dcsp_host_model.sv
/*
 Controller model for the serial link of the peripheral.
 Assumes clock_in runs at 50 MHz, so a half link clock period is four cycles.
*/
`timescale 1ns/100ps
module dcsp_host_model
(
   // Clock.
   input  wire logic   clock_in,
   // Link pins.
   input  wire logic   sdo_in,
   output logic        chip_select_n_out,
   output logic        sclk_out,
   output logic        sdi_out,
   // Captured word.
   output logic [31:0] rx_word_out,
   output logic        rx_valid_out
);
   //****************************************
   // Frame driver
   //****************************************
   // Idle levels: select high, clock low.
   initial
   begin
      chip_select_n_out = 1'b1;
      sclk_out = 1'b0;
      sdi_out = 1'b0;
      rx_word_out = 32'h00000000;
      rx_valid_out = 1'b0;
   end

   // Runs one frame of nbits clocks from the top of tx; only whole words are reported.
   task automatic frame(input int nbits, input logic [31:0] tx);
      logic [31:0] rx;
      rx = 32'h00000000;
      @(posedge clock_in);
      sclk_out <= 1'b0;
      chip_select_n_out <= 1'b0;
      repeat (8) @(posedge clock_in);
      for (int i = 0; i < nbits; i++)
      begin
         sclk_out <= 1'b1;
         sdi_out <= tx[31 - i];
         repeat (4) @(posedge clock_in);
         sclk_out <= 1'b0;
         repeat (2) @(posedge clock_in);
         rx = {rx[30:0], sdo_in};
         repeat (2) @(posedge clock_in);
      end
      chip_select_n_out <= 1'b1;
      sdi_out <= ~sdi_out;
      rx_word_out <= rx;
      rx_valid_out <= (nbits % 16 == 0);
      @(posedge clock_in);
      rx_valid_out <= 1'b0;
      repeat (8) @(posedge clock_in);
   endtask
endmodule

// File: verification/dcsp_peripheral_tb.sv
/*
 Self-checking bench for the serial peripheral: reads, writes, errors, locks.
 Assumes the controller model and the design files are compiled first.
*/
`timescale 1ns/100ps
`include "dcsp_cfg.svh"
module dcsp_peripheral_tb;
   //****************************************
   // Signals
   //****************************************
   localparam logic [7:0] IDENT = 8'ha5;  // Arbitrary identity value.
   logic        clock_in;
   logic        srst_in;
   logic        cs_n, sclk, sdi, sdo, sdo_oe, clr, err, pump, rx_valid, err_exp;
   logic [1:0]  open_load_active, lso, hso;
   logic [3:0]  other;
   logic [7:0]  out_ctl, v;
   logic [7:0]  vals[4];
   logic [31:0] cfg;
   logic [63:0] e;
   logic [31:0] rx_word;
   logic [31:0] rst_cfg = `DCSP_RST_CFG;  // Configuration reset bytes.
   logic        sdo_line;                  // Data line as the controller sees it.
   logic [63:0] exp_q[$];  // Mask and expected word per frame.
   int          fail_count = 0;
   int          check_count = 0;
   int          clr_seen = 0;
   integer      seed = 32'h32bf;

   // Free running 50 MHz clock.
   initial
   begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end

   dcsp_peripheral #(.IDENTITY(IDENT)) dut_u
   (
      .clock_in(clock_in), .srst_in(srst_in), .chip_select_n_in(cs_n), .sclk_in(sclk),
      .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .open_load_active_in(open_load_active),
      .low_side_overcurrent_in(lso), .high_side_overcurrent_in(hso), .pump_undervoltage_in(pump),
      .other_faults_in(other), .out_control_out(out_ctl), .config_out(cfg),
      .fault_clear_out(clr), .frame_error_out(err)
   );

   dcsp_host_model dcsp_host_u
   (
      .clock_in(clock_in), .sdo_in(sdo_line), .chip_select_n_out(cs_n), .sclk_out(sclk),
      .sdi_out(sdi), .rx_word_out(rx_word), .rx_valid_out(rx_valid)
   );

   //****************************************
   // Checking
   //****************************************
   // A released data line shows the inverse of the last bit, so a late enable shows up.
   assign sdo_line = sdo_oe ? sdo : ~sdo;

   // Expected status byte: error flag stands where undervoltage would.
   function automatic logic [7:0] status_exp();
      return {2'b11, err_exp, |{open_load_active, lso, hso}, other};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("BAD time=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask

   // Notes the expected word, then runs the frame.
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] data, input logic [7:0] rep,
                       input logic [7:0] rmask);
      exp_q.push_back({16'h0000, 8'hff, rmask, 16'h0000, status_exp(), rep});
      dcsp_host_u.frame(16, {cmd, data, 16'h0000});
   endtask

   // Compares each received word with the oldest note; counts clear pulses.
   always @(posedge clock_in)
   begin
      if (rx_valid === 1'b1)
      begin
         e = exp_q.pop_front();
         if (e[63:48] != 16'h0000)
            chk(rx_word[31:16] & e[63:48], e[31:16] & e[63:48]);
         chk(rx_word[15:0] & e[47:32], e[15:0] & e[47:32]);
      end
      if (clr === 1'b1)
         clr_seen++;
   end

   task automatic test_done();
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Cuts a hang short.
   initial
   begin
      #200000;
      fail_count++;
      test_done();
   end

   //****************************************
   // Scenarios
   //****************************************
   initial
   begin
      srst_in = 1'b1;
      {pump, other, open_load_active, lso, hso} = 11'h000;
      err_exp = 1'b0;
      repeat (3) @(posedge clock_in);
      srst_in <= 1'b0;
      repeat (6) @(posedge clock_in);
      xfer(8'h40, 8'h00, IDENT, 8'hff);
      xfer(8'h41, 8'h00, 8'h40, 8'hff);
      xfer(8'h43, 8'h00, 8'h80, 8'hff);
      // Each configuration register: write reports old value, read reports new.
      for (int k = 0; k < 4; k++)
      begin
         vals[k] = 8'($random(seed));
         xfer({2'b00, 6'h0a + 6'(k)}, vals[k], rst_cfg[8*k +: 8], 8'hff);
         xfer({2'b01, 6'h0a + 6'(k)}, 8'h00, vals[k], 8'hff);
         chk({8'h00, cfg[8*k +: 8]}, {8'h00, vals[k]});
      end
      v = 8'($random(seed)) & 8'hf3;
      xfer(8'h09, v, 8'h0c, 8'hff);
      chk({8'h00, out_ctl}, {8'h00, v});
      // Reserved address raises the error flag.
      xfer(8'h7f, 8'h00, 8'h00, 8'h00);
      err_exp = 1'b1;
      chk({15'h0000, err}, 16'h0001);
      // Fault clear command: status still shows the error, then it clears.
      xfer(8'h08, 8'h81, 8'h09, 8'hff);
      err_exp = 1'b0;
      chk({15'h0000, err}, 16'h0000);
      chk(16'(clr_seen), 16'h0001);
      // Short frame: error, write discarded, output released.
      dcsp_host_u.frame(12, {8'h0b, 8'h3c, 16'h0000});
      err_exp = 1'b1;
      chk({15'h0000, err}, 16'h0001);
      chk({8'h00, cfg[15:8]}, {8'h00, vals[1]});
      chk({15'h0000, sdo_oe}, 16'h0000);
      // Lock the configuration, then a write must be dropped.
      xfer(8'h08, 8'h06, 8'h01, 8'h7f);
      xfer(8'h0a, ~vals[0], vals[0], 8'hff);
      chk({8'h00, cfg[7:0]}, {8'h00, vals[0]});
      // Random fault levels reach the digest and the status byte.
      @(posedge clock_in);
      {pump, other, open_load_active, lso, hso} <= 11'($random(seed));
      repeat (4) @(posedge clock_in);
      xfer(8'h41, 8'h00, {2'b01, pump, |{open_load_active, lso, hso}, other}, 8'hff);
      // One device chain: read back under lock, global clear in the second header.
      exp_q.push_back({32'hffffffff, status_exp(), 8'h81, 8'ha0, vals[0]});
      dcsp_host_u.frame(32, {8'h81, 8'ha0, 8'h4a, 8'h00});
      err_exp = 1'b0;
      chk({15'h0000, err}, 16'h0000);
      chk(16'(clr_seen), 16'h0002);
      repeat (4) @(posedge clock_in);
      test_done();
   end
endmodule
